// ---- hdl/capture_compare_unit.sv ----
// sixteen-channel capture/compare array with two reloadable 16-bit time bases
// assumes external pins arrive asynchronously; ext_timer_overflow is a clk pulse
// Summary of operation
// - sixteen channels; one-cycle resolution, eight cycles when staggered.
// - two independent 16-bit timers, each with its own reload register.
// - each timer counts on a selectable prescaled division of the clock.
// - a timer may count on overflows of the external general timer.
// - the first timer may count events on a dedicated count pin.
// - sixteen registers, each usable for capture or compare.
// - each register picks either timer and capture or compare individually.
// - each channel owns one pin: capture input or compare output.
// - mode 0 match raises only a request, every match counts.
// - mode 1 match inverts the pin, every match counts.
// - mode 2 match raises a request, at most once per period.
// - mode 3 sets pin on first match, clears on overflow, once per period.
// - double register mode: two registers toggle one shared pin on either match.
// - single event option stops compare actions after the first one.
// - capture edge copies the allocated timer count into the register.
// - each capture raises that channel's own request.
// - capture edge selects rising, falling or both transitions.
// - compare channels check their timer on every count and act on equality.
`timescale 1ns/1ps
module capture_compare_unit
    import capcom_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic staggered,
    input wire logic run_a,
    input wire logic run_b,
    input wire logic [capcom_pkg::SEL_WIDTH-1:0] clk_sel_a,
    input wire logic [capcom_pkg::SEL_WIDTH-1:0] clk_sel_b,
    input wire logic [capcom_pkg::TIMER_WIDTH-1:0] reload_a,
    input wire logic [capcom_pkg::TIMER_WIDTH-1:0] reload_b,
    input wire logic timer_a_wr,
    input wire logic timer_b_wr,
    input wire logic [capcom_pkg::TIMER_WIDTH-1:0] timer_wr_data,
    input wire logic ext_timer_overflow,
    input wire logic count_pin,
    input wire logic [capcom_pkg::CH_COUNT-1:0] ch_alloc,
    input wire logic [capcom_pkg::CH_COUNT*capcom_pkg::MODE_WIDTH-1:0] ch_mode,
    input wire logic [capcom_pkg::CH_COUNT*capcom_pkg::EDGE_WIDTH-1:0] ch_edge,
    input wire logic [capcom_pkg::CH_COUNT-1:0] ch_single,
    input wire logic [capcom_pkg::HALF_COUNT-1:0] dbl_pair,
    input wire logic [capcom_pkg::CH_COUNT-1:0] ch_wr,
    input wire logic [capcom_pkg::TIMER_WIDTH-1:0] ch_wr_data,
    input wire logic [capcom_pkg::CH_COUNT-1:0] cc_pin_in,
    output logic [capcom_pkg::CH_COUNT-1:0] cc_pin_out,
    output logic [capcom_pkg::CH_COUNT-1:0] cc_pin_oe_n,
    output logic [capcom_pkg::CH_COUNT*capcom_pkg::TIMER_WIDTH-1:0] ch_value,
    output logic [capcom_pkg::CH_COUNT-1:0] ch_irq,
    output logic [capcom_pkg::TIMER_WIDTH-1:0] count_a,
    output logic [capcom_pkg::TIMER_WIDTH-1:0] count_b
);
    import capcom_pkg::*;

    logic [STAGGER_WIDTH-1:0] stagger_cnt;
    logic count_sync1;
    logic count_sync2;
    logic count_prev;
    logic [CH_COUNT-1:0] pin_sync1;
    logic [CH_COUNT-1:0] pin_sync2;
    logic adv_a;
    logic adv_b;
    logic ovf_a;
    logic ovf_b;
    logic [CH_COUNT-1:0] ch_match;

    // staggered operation slows the prescaled time base to one step per eight cycles for divide settings 0..3
    localparam logic [STAGGER_WIDTH-1:0] STAGGER_LAST = STAGGER_WIDTH'(STAGGER_CYCLES - 1);
    wire tick_gate = !staggered || (stagger_cnt == STAGGER_LAST);
    // count pin counts rising transitions after synchronisation
    wire count_event = count_sync2 && !count_prev;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stagger_cnt <= '0;
            count_sync1 <= 1'b0;
            count_sync2 <= 1'b0;
            count_prev <= 1'b0;
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end
        else
        begin
            stagger_cnt <= stagger_cnt + STAGGER_WIDTH'(1);
            // two flops per pin; pulses shorter than a cycle may be missed
            count_sync1 <= count_pin;
            count_sync2 <= count_sync1;
            count_prev <= count_sync2;
            pin_sync1 <= cc_pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    time_base #(.WIDTH(TIMER_WIDTH), .PIN_ALLOWED(1'b1)) u_time_base_a
    (
        .clk(clk),
        .rst(rst),
        .run(run_a),
        .clk_sel(clk_sel_a),
        .ext_overflow(ext_timer_overflow),
        .count_event(count_event),
        .tick_gate(tick_gate),
        .reload(reload_a),
        .load(timer_a_wr),
        .load_data(timer_wr_data),
        .count(count_a),
        .advanced(adv_a),
        .overflow(ovf_a)
    );

    // the count pin belongs to the first time base only
    time_base #(.WIDTH(TIMER_WIDTH), .PIN_ALLOWED(1'b0)) u_time_base_b
    (
        .clk(clk),
        .rst(rst),
        .run(run_b),
        .clk_sel(clk_sel_b),
        .ext_overflow(ext_timer_overflow),
        .count_event(1'b0),
        .tick_gate(tick_gate),
        .reload(reload_b),
        .load(timer_b_wr),
        .load_data(timer_wr_data),
        .count(count_b),
        .advanced(adv_b),
        .overflow(ovf_b)
    );

    genvar i;
    generate
        for (i = 0; i < CH_COUNT; i++)
        begin : g_ch
            wire [MODE_WIDTH-1:0] mode = ch_mode[i*MODE_WIDTH +: MODE_WIDTH];
            wire [TIMER_WIDTH-1:0] sel_count = ch_alloc[i] ? count_b : count_a;
            wire sel_adv = ch_alloc[i] ? adv_b : adv_a;
            wire sel_ovf = ch_alloc[i] ? ovf_b : ovf_a;
            wire lower = (i < HALF_COUNT);
            wire pair_on = dbl_pair[i % HALF_COUNT];
            wire dbl = lower && pair_on;
            wire partner = lower ? ch_match[(i + HALF_COUNT) % CH_COUNT] : 1'b0;
            // the upper register of a pair gives up its pin to the lower one
            wire drives = dbl || (!(pair_on && !lower) &&
                          ((mode == MODE_CMP1) || (mode == MODE_CMP3)));

            capcom_channel #(.WIDTH(TIMER_WIDTH)) u_channel
            (
                .clk(clk),
                .rst(rst),
                .mode(mode),
                .edge_sel(ch_edge[i*EDGE_WIDTH +: EDGE_WIDTH]),
                .single_event(ch_single[i]),
                .double_mode(dbl),
                .partner_match(partner),
                .timer_count(sel_count),
                .timer_advanced(sel_adv),
                .timer_overflow(sel_ovf),
                .pin_level(pin_sync2[i]),
                .wr(ch_wr[i]),
                .wr_data(ch_wr_data),
                .value(ch_value[i*TIMER_WIDTH +: TIMER_WIDTH]),
                .irq(ch_irq[i]),
                .match(ch_match[i]),
                .pin_out(cc_pin_out[i])
            );

            assign cc_pin_oe_n[i] = !drives;
        end
    endgenerate

    // checks on both time bases and channel 0
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire [MODE_WIDTH-1:0] mode0 = ch_mode[MODE_WIDTH-1:0];
    wire [TIMER_WIDTH-1:0] count0 = g_ch[0].sel_count;
    wire ovf0 = g_ch[0].sel_ovf;

    sequence s_cmp2_hit;
        (mode0 == MODE_CMP2) && ch_match[0];
    endsequence

    sequence s_cmp2_same_period;
        (mode0 == MODE_CMP2) && !ovf0 && !ch_wr[0];
    endsequence

    sequence s_single_hit;
        ch_single[0] && ch_match[0] && !ch_wr[0];
    endsequence

    sequence s_no_rearm;
        !ch_wr[0] && ch_single[0];
    endsequence

    AST_TIMER_RELOAD: assert property (ovf_a && !$past(timer_a_wr) |->
        count_a == $past(reload_a))
        else $error("timer a did not load its reload value on overflow");

    AST_TIMER_STEP: assert property (adv_a && !ovf_a |->
        count_a == $past(count_a) + TIMER_WIDTH'(1))
        else $error("timer a did not step by one");

    AST_STAGGER: assert property (staggered && $past(staggered) && adv_a &&
        ($past(clk_sel_a) <= SRC_DIV_MAX) |-> $past(stagger_cnt) == STAGGER_LAST)
        else $error("staggered timer stepped off the eight-cycle grid");

    AST_CAPTURE: assert property ((mode0 == MODE_CAPTURE) && ch_edge[EDGE_RISE_BIT] &&
        pin_sync2[0] && !$past(pin_sync2[0]) |=>
        (ch_value[TIMER_WIDTH-1:0] == $past(count0)) && ch_irq[0])
        else $error("rising capture did not latch the timer and request");

    AST_MODE1_TOGGLE: assert property ((mode0 == MODE_CMP1) && !dbl_pair[0] &&
        $changed(cc_pin_out[0]) && $past(mode0 == MODE_CMP1) |-> ch_irq[0])
        else $error("mode 1 pin changed without a match");

    AST_MODE3_CLEAR: assert property ((mode0 == MODE_CMP3) && !dbl_pair[0] && ovf0 &&
        !ch_match[0] |=> !cc_pin_out[0])
        else $error("mode 3 pin not cleared on overflow");

    AST_MODE2_ONCE: assert property (s_cmp2_hit ##1 s_cmp2_same_period [*3] |->
        !ch_match[0])
        else $error("mode 2 matched twice in one period");

    AST_SINGLE_EVENT: assert property (s_single_hit ##1 s_no_rearm [*4] |->
        !ch_match[0])
        else $error("single event channel acted again");

    AST_PIN_DRIVE: assert property ((mode0 == MODE_CMP1) && !dbl_pair[0] |->
        !cc_pin_oe_n[0] ##1 1'b1)
        else $error("mode 1 channel does not drive its pin");

    AST_CAPTURE_RELEASE: assert property ((mode0 == MODE_CAPTURE) && !dbl_pair[0] |->
        cc_pin_oe_n[0])
        else $error("capture channel drives its pin");

    sequence s_fall_cap0;
        (mode0 == MODE_CAPTURE) && ch_edge[EDGE_FALL_BIT] &&
        !pin_sync2[0] && $past(pin_sync2[0]);
    endsequence

    sequence s_fall_skip0;
        (mode0 == MODE_CAPTURE) && !ch_edge[EDGE_FALL_BIT] &&
        !pin_sync2[0] && $past(pin_sync2[0]);
    endsequence

    AST_TIMER_B_RELOAD: assert property (ovf_b |-> count_b == $past(reload_b))
        else $error("timer b did not load its reload value");

    AST_TIMER_B_STEP: assert property (adv_b && !ovf_b |->
        count_b == $past(count_b) + TIMER_WIDTH'(1))
        else $error("timer b did not step by one");

    AST_TIMER_LOAD: assert property (timer_a_wr |=>
        count_a == $past(timer_wr_data))
        else $error("timer a write was lost");

    // a stopped time base must hold its count
    AST_TIMER_HOLD: assert property (!$past(run_a) && !$past(timer_a_wr) |->
        $stable(count_a))
        else $error("stopped timer a moved");

    AST_EXT_COUNT: assert property (run_a && (clk_sel_a == SRC_EXT_OVF) &&
        ext_timer_overflow && !timer_a_wr |=> adv_a)
        else $error("timer a missed an external overflow");

    AST_PIN_COUNT: assert property (run_a && (clk_sel_a == SRC_PIN) &&
        count_event && !timer_a_wr |=> adv_a)
        else $error("timer a missed a count pin edge");

    AST_B_NO_PIN: assert property ((clk_sel_b == SRC_PIN) |=> !adv_b)
        else $error("timer b counted the count pin");

    // divide by two never steps on two cycles in a row
    AST_DIV_TWO: assert property (adv_a && ($past(clk_sel_a) == 3'h1) &&
        ($past(clk_sel_a, 2) == 3'h1) |-> !$past(adv_a))
        else $error("timer a stepped faster than divide by two");

    AST_MODE0_PIN: assert property (($past(mode0) == MODE_CMP0) && !$past(dbl_pair[0]) |->
        $stable(cc_pin_out[0]))
        else $error("mode 0 channel moved its pin");

    AST_MODE2_PIN: assert property (($past(mode0) == MODE_CMP2) && !$past(dbl_pair[0]) |->
        $stable(cc_pin_out[0]))
        else $error("mode 2 channel moved its pin");

    AST_COMPARE_HIT: assert property ((mode0 == MODE_CMP0) && g_ch[0].sel_adv &&
        (count0 == ch_value[TIMER_WIDTH-1:0]) && !g_ch[0].u_channel.done |-> ch_match[0])
        else $error("equal count gave no match");

    AST_CAPTURE_FALL: assert property (s_fall_cap0 |=>
        (ch_value[TIMER_WIDTH-1:0] == $past(count0)) && ch_irq[0])
        else $error("falling capture did not latch the timer");

    AST_RISE_ONLY: assert property (s_fall_skip0 |=> !ch_irq[0])
        else $error("rising-only capture fired on a fall");

    AST_MODE3_SET: assert property ((mode0 == MODE_CMP3) && ch_match[0] |=>
        cc_pin_out[0])
        else $error("mode 3 pin not set on match");

    AST_PAIR_PIN: assert property (dbl_pair[0] |->
        !cc_pin_oe_n[0] && cc_pin_oe_n[HALF_COUNT])
        else $error("pair 0 does not share the lower pin");
endmodule

// ---- common/capcom_pkg.sv ----
// constants shared by the capture/compare array and its time bases
// assumes a single synchronous clock domain for every user
package capcom_pkg;
    localparam int CH_COUNT = 16;
    localparam int HALF_COUNT = 8;
    localparam int TIMER_WIDTH = 16;
    localparam int PRE_WIDTH = 5;
    localparam int SEL_WIDTH = 3;
    localparam int MODE_WIDTH = 3;
    localparam int EDGE_WIDTH = 2;
    localparam int STAGGER_CYCLES = 8;
    localparam int STAGGER_WIDTH = 3;

    // channel function codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_CAPTURE = 3'h1;
    localparam logic [2:0] MODE_CMP0 = 3'h4;
    localparam logic [2:0] MODE_CMP1 = 3'h5;
    localparam logic [2:0] MODE_CMP2 = 3'h6;
    localparam logic [2:0] MODE_CMP3 = 3'h7;
    localparam int MODE_CMP_BIT = 2;

    // capture edge select bits
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;

    // timer count source: 0..5 divide by 2**sel, then the two event sources
    localparam logic [2:0] SRC_DIV_MAX = 3'h5;
    localparam logic [2:0] SRC_EXT_OVF = 3'h6;
    localparam logic [2:0] SRC_PIN = 3'h7;

    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [4:0] PRE_RESET = 5'h00;
    localparam logic [4:0] PRE_ALL = 5'h1F;
endpackage

// ---- hdl/time_base.sv ----
// one reloadable up-counting time base with prescaler and event sources
// assumes event inputs are one-cycle pulses already in the clk domain
`timescale 1ns/1ps
module time_base
    import capcom_pkg::*;
#(
    parameter int WIDTH = TIMER_WIDTH,
    parameter bit PIN_ALLOWED = 1'b1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [capcom_pkg::SEL_WIDTH-1:0] clk_sel,
    input wire logic ext_overflow,
    input wire logic count_event,
    input wire logic tick_gate,
    input wire logic [WIDTH-1:0] reload,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_data,
    output logic [WIDTH-1:0] count,
    output logic advanced,
    output logic overflow
);
    import capcom_pkg::*;

    logic [PRE_WIDTH-1:0] pre;
    wire [PRE_WIDTH-1:0] pre_mask = PRE_WIDTH'(~(PRE_ALL << clk_sel));
    wire prescale_hit = ((pre & pre_mask) == pre_mask) && tick_gate;
    wire pin_hit = PIN_ALLOWED && count_event;
    wire source_tick = (clk_sel <= SRC_DIV_MAX) ? prescale_hit :
                       (clk_sel == SRC_EXT_OVF) ? ext_overflow :
                       pin_hit;
    wire step = run && source_tick && !load;
    wire wrap = (count == {WIDTH{1'b1}});

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pre <= PRE_RESET;
            count <= WIDTH'(COUNT_RESET);
            advanced <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            pre <= pre + PRE_WIDTH'(1);
            if (load)
                count <= load_data;
            else if (step)
                count <= wrap ? reload : count + WIDTH'(1);
            advanced <= step;
            overflow <= step && wrap;
        end
    end
endmodule

// ---- hdl/capcom_channel.sv ----
// one capture/compare channel: register, capture edge logic, compare actions
// assumes pin_level is already synchronised and the timer signals are registered
`timescale 1ns/1ps
module capcom_channel
    import capcom_pkg::*;
#(
    parameter int WIDTH = TIMER_WIDTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [capcom_pkg::MODE_WIDTH-1:0] mode,
    input wire logic [capcom_pkg::EDGE_WIDTH-1:0] edge_sel,
    input wire logic single_event,
    input wire logic double_mode,
    input wire logic partner_match,
    input wire logic [WIDTH-1:0] timer_count,
    input wire logic timer_advanced,
    input wire logic timer_overflow,
    input wire logic pin_level,
    input wire logic wr,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value,
    output logic irq,
    output logic match,
    output logic pin_out
);
    import capcom_pkg::*;

    logic prev_pin;
    logic fired;
    logic done;

    wire rise = pin_level && !prev_pin;
    wire fall = !pin_level && prev_pin;
    wire is_capture = (mode == MODE_CAPTURE);
    wire is_compare = mode[MODE_CMP_BIT];
    wire cap_hit = is_capture && ((edge_sel[EDGE_RISE_BIT] && rise) ||
                   (edge_sel[EDGE_FALL_BIT] && fall));
    // compare only on a fresh count, so a stopped timer gives one match
    wire equal = is_compare && timer_advanced && (timer_count == value) && !done;
    wire once_mode = (mode == MODE_CMP2) || (mode == MODE_CMP3);
    wire act = equal && !(once_mode && fired);
    wire toggle_pin = double_mode ? (act || (partner_match && !done)) :
                      ((mode == MODE_CMP1) && act);

    assign match = act;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_pin <= 1'b0;
            value <= WIDTH'(VALUE_RESET);
            irq <= 1'b0;
            fired <= 1'b0;
            done <= 1'b0;
            pin_out <= 1'b0;
        end
        else
        begin
            prev_pin <= pin_level;
            // a capture in the write cycle wins, so no event is lost
            if (cap_hit)
                value <= timer_count;
            else if (wr)
                value <= wr_data;
            irq <= cap_hit || act;
            // overflow opens a new period; a match in that cycle belongs to it
            fired <= act || (fired && !timer_overflow);
            // rewriting the register rearms a finished single event
            done <= (single_event && act) || (done && !wr);
            if ((mode == MODE_CMP3) && act)
                pin_out <= 1'b1;
            else if ((mode == MODE_CMP3) && timer_overflow && !double_mode)
                pin_out <= 1'b0;
            else if (toggle_pin)
                pin_out <= ~pin_out;
        end
    end
endmodule

// ---- bench/pin_model.sv ----
// far-side pin model: capture trigger sources and the timer count input
// assumes the bench calls its tasks; levels change at falling clk edges
`timescale 1ns/1ps
module pin_model
(
    input wire logic clk,
    input wire logic [capcom_pkg::CH_COUNT-1:0] cc_pin_out,
    input wire logic [capcom_pkg::CH_COUNT-1:0] cc_pin_oe_n,
    output logic [capcom_pkg::CH_COUNT-1:0] cc_pin_in,
    output logic count_pin
);
    import capcom_pkg::*;
    logic [CH_COUNT-1:0] ext_level;
    // unit wins where it drives, outside level elsewhere
    assign cc_pin_in = (~cc_pin_oe_n & cc_pin_out) | (cc_pin_oe_n & ext_level);
    initial
    begin
        ext_level = '0;
        count_pin = 1'b0;
    end
    // three cycles per level, well above the sync depth
    task automatic set_pin(input int ch, input logic lvl);
        @(negedge clk);
        ext_level[ch] = lvl;
        repeat (3) @(negedge clk);
    endtask
    task automatic count_pulses(input int n);
        repeat (n)
        begin
            @(negedge clk);
            count_pin = 1'b1;
            repeat (2) @(negedge clk);
            count_pin = 1'b0;
            @(negedge clk);
        end
    endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the sixteen-channel capture/compare unit
// assumes pin_model on the far side; inputs change at falling edges
`timescale 1ns/1ps
module tb_top;
    import capcom_pkg::*;
    logic clk, rst, staggered, ext_timer_overflow, count_pin, cap_on;
    logic [1:0] run, twr;
    logic [2:0] sel [2];
    logic [15:0] rl [2];
    logic [15:0] timer_wr_data, ch_wr_data, count_a, count_b;
    logic [CH_COUNT-1:0] ch_alloc, ch_single, ch_wr, cc_pin_in, cc_pin_out;
    logic [CH_COUNT-1:0] cc_pin_oe_n, ch_irq, last_pin;
    logic [CH_COUNT*MODE_WIDTH-1:0] ch_mode;
    logic [CH_COUNT*EDGE_WIDTH-1:0] ch_edge;
    logic [HALF_COUNT-1:0] dbl_pair;
    logic [CH_COUNT*TIMER_WIDTH-1:0] ch_value;
    int num_errors, checks_done, cap_ch, tsel;
    int irq_cnt [CH_COUNT];
    int tog_cnt [CH_COUNT];
    logic [2:0] md [7] = '{MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3,
        MODE_CMP1, MODE_CMP0, MODE_CMP1};
    logic [6:0] sg = 7'h30;
    logic [6:0] db = 7'h40;
    int ei [7] = '{3, 3, 2, 2, 1, 1, 3};
    int et [7] = '{0, 3, 0, 3, 1, 0, 6};

    capture_compare_unit uut (.clk(clk), .rst(rst), .staggered(staggered), .run_a(run[0]),
        .run_b(run[1]), .clk_sel_a(sel[0]), .clk_sel_b(sel[1]), .reload_a(rl[0]),
        .reload_b(rl[1]), .timer_a_wr(twr[0]), .timer_b_wr(twr[1]),
        .timer_wr_data(timer_wr_data), .ext_timer_overflow(ext_timer_overflow),
        .count_pin(count_pin), .ch_alloc(ch_alloc), .ch_mode(ch_mode), .ch_edge(ch_edge),
        .ch_single(ch_single), .dbl_pair(dbl_pair), .ch_wr(ch_wr), .ch_wr_data(ch_wr_data),
        .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n),
        .ch_value(ch_value), .ch_irq(ch_irq), .count_a(count_a), .count_b(count_b));
    pin_model pins (.clk(clk), .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n),
        .cc_pin_in(cc_pin_in), .count_pin(count_pin));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [15:0] cnt(input int t);
        return (t == 0) ? count_a : count_b;
    endfunction

    always @(posedge clk)
    begin
        for (int i = 0; i < CH_COUNT; i++)
        begin
            irq_cnt[i] += int'(ch_irq[i] === 1'b1);
            tog_cnt[i] += int'(cc_pin_out[i] !== last_pin[i]);
        end
        last_pin <= cc_pin_out;
    end

    // timer steps every cycle here, so the capture saw one count less
    always @(negedge clk)
        if (cap_on && ch_irq[cap_ch] === 1'b1)
            check(ch_value[16 * cap_ch +: 16], cnt(tsel) - 16'h0001);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic set_t(input int t, input logic r, input logic [2:0] s, input logic [15:0] l);
        @(negedge clk);
        run[t] = r;
        sel[t] = s;
        rl[t] = l;
    endtask

    task automatic load(input int t, input logic [15:0] d);
        @(negedge clk);
        timer_wr_data = d;
        twr[t] = 1'b1;
        @(negedge clk);
        twr = '0;
    endtask

    task automatic wr_ch(input int ch, input logic [15:0] d);
        @(negedge clk);
        ch_wr_data = d;
        ch_wr[ch] = 1'b1;
        @(negedge clk);
        ch_wr = '0;
    endtask

    task automatic interval(input int t, output int n);
        logic [15:0] c0;
        c0 = cnt(t);
        for (int i = 0; i < 99 && cnt(t) === c0; i++) @(negedge clk);
        c0 = cnt(t);
        for (n = 0; n < 99 && cnt(t) === c0; n++) @(negedge clk);
    endtask

    task automatic clear();
        foreach (irq_cnt[i])
        begin
            irq_cnt[i] = 0;
            tog_cnt[i] = 0;
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
    endtask

    // whole run is near 1000 cycles; ten times that is a hang
    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end

    initial
    begin
        logic [15:0] v;
        int k, n, ch, t;
        {staggered, ext_timer_overflow, cap_on, run, twr} = '0;
        sel = '{2{3'h0}};
        rl = '{2{16'h0000}};
        {timer_wr_data, ch_wr_data, ch_alloc, ch_single, ch_wr, dbl_pair} = '0;
        {ch_mode, ch_edge, last_pin} = '0;
        {num_errors, checks_done, cap_ch, tsel} = '0;
        rst = 1'b1;
        void'($urandom(32'hDAAD));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        check(count_a, 16'h0000);
        check(cc_pin_out | ch_irq, 16'h0000);
        for (t = 0; t < 2; t++)
        begin
            v = 16'($urandom_range(0, 16'hF000));
            // an all-ones reload would freeze the count at the top
            set_t(t, 1'b1, 3'h0, 16'($urandom_range(0, 16'hFFFE)));
            load(t, v);
            repeat (10) @(negedge clk);
            check(cnt(t), v + 16'h000A);
            load(t, 16'hFFFE);
            repeat (3) @(negedge clk);
            check(cnt(t), rl[t] + 16'h0001);
            for (int s = 1; s <= 5; s++)
            begin
                set_t(t, 1'b1, 3'(s), rl[t]);
                interval(t, n);
                check(16'(n), 16'(1 << s));
            end
            staggered = 1'b1;
            set_t(t, 1'b1, 3'h0, rl[t]);
            interval(t, n);
            check(16'(n), 16'h0008);
            staggered = 1'b0;
            set_t(t, 1'b1, SRC_EXT_OVF, 16'h0000);
            load(t, 16'h0000);
            k = $urandom_range(1, 9);
            repeat (k)
            begin
                ext_timer_overflow = 1'b1;
                @(negedge clk);
                ext_timer_overflow = 1'b0;
                repeat ($urandom_range(1, 3)) @(negedge clk);
            end
            check(cnt(t), 16'(k));
            set_t(t, 1'b1, SRC_PIN, 16'h0000);
            load(t, 16'h0000);
            pins.count_pulses(k);
            repeat (4) @(negedge clk);
            check(cnt(t), (t == 0) ? 16'(k) : 16'h0000);
            set_t(t, 1'b0, 3'h0, 16'h0000);
            $display("timer %0d tests done", t);
        end
        for (int r = 0; r < 7; r++)
        begin
            ch = $urandom_range(0, 7);
            t = $urandom_range(0, 1);
            v = 16'hFFF0 - 16'($urandom_range(0, 15));
            do_reset();
            ch_alloc = 16'($urandom);
            ch_alloc[ch] = t[0];
            ch_alloc[ch + 8] = t[0];
            set_t(t, 1'b0, 3'h0, v - 16'h0004);
            load(t, v - 16'h0002);
            wr_ch(ch, v);
            wr_ch(ch + 8, v + 16'h0001);
            ch_mode = '0;
            ch_mode[3 * ch +: 3] = md[r];
            ch_mode[3 * ch + 24 +: 3] = db[r] ? MODE_CMP1 : MODE_OFF;
            ch_single = '0;
            ch_single[ch] = sg[r];
            dbl_pair = '0;
            dbl_pair[ch] = db[r];
            clear();
            run[t] = 1'b1;
            repeat (8) @(negedge clk);
            // second pass inside the same period, then one after overflow
            load(t, v - 16'h0002);
            for (int i = 0; i < 99 && cnt(t) !== v - 16'h0004; i++) @(negedge clk);
            repeat (8) @(negedge clk);
            run[t] = 1'b0;
            repeat (3) @(negedge clk);
            check(16'(irq_cnt[ch]), 16'(ei[r]));
            check(16'(tog_cnt[ch]), 16'(et[r]));
            check(16'(irq_cnt[ch + 8]), db[r] ? 16'h0003 : 16'h0000);
            check(16'(cc_pin_oe_n[ch]), 16'(!(md[r][0] | db[r])));
            $display("compare row %0d done", r);
        end
        for (int e = 1; e <= 3; e++)
        begin
            ch = $urandom_range(0, 15);
            t = $urandom_range(0, 1);
            do_reset();
            ch_mode = '0;
            // a pair left from the compare rows would drive the capture pin
            dbl_pair = '0;
            ch_mode[3 * ch +: 3] = MODE_CAPTURE;
            ch_edge[2 * ch +: 2] = 2'(e);
            ch_alloc[ch] = t[0];
            set_t(t, 1'b1, 3'h0, 16'h0000);
            load(t, 16'($urandom_range(0, 16'h8000)));
            clear();
            cap_ch = ch;
            tsel = t;
            cap_on = 1'b1;
            pins.set_pin(ch, 1'b1);
            pins.set_pin(ch, 1'b0);
            repeat (4) @(negedge clk);
            cap_on = 1'b0;
            check(16'(irq_cnt[ch]), (e == 3) ? 16'h0002 : 16'h0001);
            set_t(t, 1'b0, 3'h0, 16'h0000);
            $display("capture edge %0d done", e);
        end
        final_report();
    end
endmodule
